// File: sdsr_pkg.sv
// package: constants, field layout and types of the startup and device status registers
`default_nettype none

package sdsr_pkg;

	// ----------------------------------------
	// register select and field layout
	// ----------------------------------------
	localparam logic        SEL_PIN_CAPTURE   = 1'b0;
	localparam logic        SEL_DEVICE_STATUS = 1'b1;
	localparam int          PIN_FIELD_W       = 2;
	localparam int          PIN_COUNT         = 3;
	localparam int          PIN_A_LSB         = 0;
	localparam int          PIN_B_LSB         = 2;
	localparam int          PIN_C_LSB         = 4;
	localparam int          FLAG_IN1_BIT      = 15;
	localparam int          FLAG_IN0_BIT      = 14;
	localparam int          READY_BIT         = 9;
	localparam int          LOCK_BIT          = 8;
	localparam int          SE_IMAGE_BIT      = 7;
	localparam int          EE_VALID_BIT      = 6;
	localparam int          OTP_VALID_BIT     = 5;
	localparam int          CFG_ID_LSB        = 0;
	localparam int          CFG_ID_W          = 5;
	localparam logic [15:0] PIN_CAPTURE_RST   = 16'h0000;
	localparam logic [15:0] DEVICE_LOAD_STATUS_RST    = 16'h0000;

	// ----------------------------------------
	// encodings
	// ----------------------------------------
	localparam logic [1:0]  TRI_LOW    = 2'h0;
	localparam logic [1:0]  TRI_MID    = 2'h1;
	localparam logic [1:0]  TRI_HIGH   = 2'h3;
	localparam logic [1:0]  FAN_OFF    = 2'h0;
	localparam logic [1:0]  FAN_AUTO   = 2'h1;
	localparam logic [1:0]  FAN_MANUAL = 2'h3;
	localparam logic [7:0]  LOCK_KEY_SET = 8'hA5;
	localparam logic [7:0]  LOCK_KEY_CLR = 8'h5A;

	// ----------------------------------------
	// synchroniser lanes and timing
	// ----------------------------------------
	localparam int          SYNC_W       = 11;
	localparam int          SB_PG        = 6;
	localparam int          SB_RSTPIN0   = 7;
	localparam int          SB_RSTPIN1   = 8;
	localparam int          SB_LOS0      = 9;
	localparam int          SB_LOS1      = 10;
	localparam logic [2:0]  SETTLE_CYCLES = 3'h4;

	typedef enum logic [1:0]
	{
		WR_CONFIG   = 2'b00,
		WR_W1C      = 2'b01,
		WR_LOCK_KEY = 2'b10,
		WR_EXEMPT   = 2'b11
	} sdsr_wr_kind_e;

	typedef enum logic [2:0]
	{
		ST_WAIT_PINS = 3'b000,
		ST_COMMON    = 3'b001,
		ST_USER      = 3'b010,
		ST_READY     = 3'b011,
		ST_RELOAD    = 3'b100
	} sdsr_state_e;

endpackage

`default_nettype wire

// File: sdsr_sync.sv
// module: three-stage pin synchroniser with agreement filter
`default_nettype none

module sdsr_sync
(
	input  wire logic clk,
	input  wire logic nrst,
	sdsr_sync_if.filt sif
);
	import sdsr_pkg::*;

	logic [SYNC_W-1:0] s1_q;
	logic [SYNC_W-1:0] s2_q;
	logic [SYNC_W-1:0] s3_q;
	logic [SYNC_W-1:0] clean_q;

	// ----------------------------------------
	// per-lane stages; the first stage feeds only the second
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < SYNC_W; i++)
		begin : g_lane
			always_ff @(posedge clk)
			if (!nrst)
			begin
				s1_q[i]    <= 1'b0;
				s2_q[i]    <= 1'b0;
				s3_q[i]    <= 1'b0;
				clean_q[i] <= 1'b0;
			end
			else
			begin
				s1_q[i] <= sif.raw[i];
				s2_q[i] <= s1_q[i];
				s3_q[i] <= s2_q[i];
				// a change counts only once two late stages agree
				if (s2_q[i] == s3_q[i])
					clean_q[i] <= s3_q[i];
			end
		end
	endgenerate

	assign sif.clean = clean_q;

endmodule

`default_nettype wire

// File: sdsr_sync_if.sv
// interface: raw pin levels in, filtered levels out of the synchroniser
`default_nettype none

interface sdsr_sync_if;
	logic [sdsr_pkg::SYNC_W-1:0] raw;
	logic [sdsr_pkg::SYNC_W-1:0] clean;

	modport filt
	(
		input  raw,
		output clean
	);

	modport user
	(
		output raw,
		input  clean
	);
endinterface

`default_nettype wire

// File: sdsr_tb.sv
// testbench: startup pin capture, loader sequence, write lock and fanout flags
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import sdsr_pkg::*;

	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic          clk = 1'b0;
	logic          nrst = 1'b0;
	logic [2:0]    pin_level_high = 3'h0;
	logic [2:0]    pin_level_low = 3'h0;
	logic          power_good_pin = 1'b0;
	logic          pg_sel = 1'b1;
	logic          rstpin0_n = 1'b1;
	logic          rstpin1_n = 1'b1;
	logic [1:0]    lost = 2'h0;
	logic [1:0]    set0 = 2'h0;
	logic [1:0]    set1 = 2'h0;
	logic          load_ack = 1'b0;
	logic          load_ok = 1'b0;
	logic          from_ee = 1'b0;
	logic          from_otp = 1'b0;
	logic          se_flag = 1'b0;
	logic [4:0]    cfg_id = 5'h00;
	logic          reload_req = 1'b0;
	logic          cfg_wr = 1'b0;
	sdsr_wr_kind_e cfg_wr_kind = WR_CONFIG;
	logic [7:0]    cfg_wdata = 8'h00;
	logic          rd_en = 1'b0;
	logic          rd_sel = 1'b0;
	logic          load_req;
	logic          load_user;
	logic          cfg_wr_ok;
	logic          lock;
	logic [15:0]   rd_data;
	logic          rd_valid;
	int            bad_count = 0;
	int            n_tests = 0;

	always #25 clk = ~clk;

	sdsr_top i_dut
	(
		.clk                        (clk),
		.nrst                       (nrst),
		.pin_level_high             (pin_level_high),
		.pin_level_low              (pin_level_low),
		.power_good_pin             (power_good_pin),
		.power_good_select          (pg_sel),
		.peripheral_reset_pin0_n    (rstpin0_n),
		.peripheral_reset_pin1_n    (rstpin1_n),
		.input_clock_zero_lost      (lost[0]),
		.input_clock_one_lost       (lost[1]),
		.input0_passthrough_setting (set0),
		.input1_passthrough_setting (set1),
		.load_ack                   (load_ack),
		.load_ok                    (load_ok),
		.load_from_eeprom           (from_ee),
		.load_from_otp              (from_otp),
		.single_ended_image_flag    (se_flag),
		.load_config_id             (cfg_id),
		.reload_req                 (reload_req),
		.cfg_wr                     (cfg_wr),
		.cfg_wr_kind                (cfg_wr_kind),
		.cfg_wdata                  (cfg_wdata),
		.rd_en                      (rd_en),
		.rd_sel                     (rd_sel),
		.load_req                   (load_req),
		.load_user                  (load_user),
		.cfg_wr_ok                  (cfg_wr_ok),
		.write_lock_status          (lock),
		.rd_data                    (rd_data),
		.rd_valid                   (rd_valid)
	);

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// one read; the answer is looked at in the single cycle that rd_valid stands
	task automatic rd(input logic sel, input logic [15:0] mask, input logic [15:0] exp);
		@(posedge clk);
		rd_en <= 1'b1;
		rd_sel <= sel;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		check({15'h0000, rd_valid}, 16'h0001);
		check(rd_data & mask, exp);
	endtask

	task automatic wr(input sdsr_wr_kind_e kind, input logic [7:0] data, input logic ok);
		@(posedge clk);
		cfg_wr <= 1'b1;
		cfg_wr_kind <= kind;
		cfg_wdata <= data;
		@(posedge clk);
		cfg_wr <= 1'b0;
		#1;
		check({15'h0000, cfg_wr_ok}, {15'h0000, ok});
	endtask

	// waits a bounded time for a loader request and checks which half it asks for
	task automatic wait_req(input logic user);
		int i;
		// looks before the first wait: the pulse may have been launched at the current edge
		for (i = 0; i < 60; i++)
		begin
			#1;
			if (load_req === 1'b1)
				break;
			@(posedge clk);
		end
		check({15'h0000, load_req}, 16'h0001);
		check({15'h0000, load_user}, {15'h0000, user});
	endtask

	task automatic ack(input logic ee, input logic otp, input logic se, input logic [4:0] id);
		@(posedge clk);
		load_ack <= 1'b1;
		load_ok <= 1'b1;
		from_ee <= ee;
		from_otp <= otp;
		se_flag <= se;
		cfg_id <= id;
		@(posedge clk);
		load_ack <= 1'b0;
	endtask

	// auto mode only changes at a reset-pin rise, so every case pulses it
	task automatic fan(input int idx, input logic [1:0] mode, input logic ls, input logic f);
		@(posedge clk);
		if (idx == 1) set1 <= mode;
		else set0 <= mode;
		lost[idx] <= ls;
		rstpin0_n <= 1'b0;
		rstpin1_n <= 1'b0;
		repeat (4) @(posedge clk);
		rstpin0_n <= 1'b1;
		rstpin1_n <= 1'b1;
		repeat (12) @(posedge clk);
		rd(1'b1, 16'h0001 << (14 + idx), {15'h0000, f} << (14 + idx));
	endtask

	// ----------------------------------------
	// watchdog: the whole sequence needs well under 1500 cycles
	// ----------------------------------------
	initial
	begin
		repeat (6000) @(posedge clk);
		bad_count++;
		tally_and_finish();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		rd(1'b0, 16'hFFFF, PIN_CAPTURE_RST);
		rd(1'b1, 16'hFFFF, DEVICE_LOAD_STATUS_RST);
		$display("test reset done");
		// pin a high (both comparators, high wins), b low, c mid
		@(posedge clk);
		pin_level_high <= 3'b001;
		pin_level_low <= 3'b011;
		repeat (20) @(posedge clk);
		rd(1'b0, 16'hFFFF, 16'h0000);
		@(posedge clk);
		power_good_pin <= 1'b1;
		wait_req(1'b0);
		@(posedge clk);
		pin_level_high <= 3'b110;
		pin_level_low <= 3'b001;
		rd(1'b0, 16'hFFFF, 16'h0013);
		@(posedge clk);
		power_good_pin <= 1'b0;
		repeat (10) @(posedge clk);
		power_good_pin <= 1'b1;
		repeat (10) @(posedge clk);
		rd(1'b0, 16'hFFFF, 16'h0013);
		$display("test pin capture done");
		ack(1'b0, 1'b0, 1'b1, 5'h00);
		wait_req(1'b1);
		rd(1'b1, 16'h0200, 16'h0000);
		ack(1'b1, 1'b0, 1'b0, 5'h15);
		rd(1'b1, 16'hFFFF, 16'h02D5);
		$display("test startup load done");
		wr(WR_CONFIG, 8'h00, 1'b1);
		wr(WR_LOCK_KEY, LOCK_KEY_SET, 1'b1);
		check({15'h0000, lock}, 16'h0001);
		wr(WR_CONFIG, 8'h00, 1'b0);
		wr(WR_W1C, 8'h00, 1'b1);
		wr(WR_EXEMPT, 8'h00, 1'b1);
		wr(WR_LOCK_KEY, 8'h33, 1'b1);
		rd(1'b1, 16'hFFFF, 16'h03D5);
		wr(WR_LOCK_KEY, LOCK_KEY_CLR, 1'b1);
		check({15'h0000, lock}, 16'h0000);
		wr(WR_CONFIG, 8'h00, 1'b1);
		$display("test write lock done");
		@(posedge clk);
		reload_req <= 1'b1;
		@(posedge clk);
		reload_req <= 1'b0;
		#1;
		check({15'h0000, load_req & load_user}, 16'h0001);
		rd(1'b1, 16'h0200, 16'h0000);
		ack(1'b0, 1'b1, 1'b0, 5'h0A);
		rd(1'b1, 16'h02FF, 16'h02AA);
		rd(1'b0, 16'hFFFF, 16'h0013);
		$display("test reload done");
		for (int i = 0; i < 2; i++)
		begin
			fan(i, FAN_OFF, 1'b0, 1'b0);
			fan(i, FAN_MANUAL, 1'b1, 1'b1);
			fan(i, 2'h2, 1'b0, 1'b0);
			fan(i, FAN_AUTO, 1'b0, 1'b1);
			fan(i, FAN_AUTO, 1'b1, 1'b0);
			fan(i, FAN_OFF, 1'b0, 1'b0);
		end
		$display("test fanout done");
		// second reset without power-good select; auto mode must not latch from reset itself
		@(posedge clk);
		nrst <= 1'b0;
		pg_sel <= 1'b0;
		set0 <= FAN_AUTO;
		pin_level_high <= 3'b010;
		pin_level_low <= 3'b001;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		rd(1'b0, 16'hFFFF, PIN_CAPTURE_RST);
		rd(1'b1, 16'hFFFF, DEVICE_LOAD_STATUS_RST);
		wait_req(1'b0);
		rd(1'b0, 16'hFFFF, 16'h001C);
		rd(1'b1, 16'hFFFF, 16'h0000);
		$display("test second reset done");
		tally_and_finish();
	end
endmodule

`default_nettype wire

// File: sdsr_top.sv
// module: startup pin capture and device load status registers
`default_nettype none

module sdsr_top
(
	input  wire logic                       clk,
	input  wire logic                       nrst,
	input  wire logic [2:0]                 pin_level_high,
	input  wire logic [2:0]                 pin_level_low,
	input  wire logic                       power_good_pin,
	input  wire logic                       power_good_select,
	input  wire logic                       peripheral_reset_pin0_n,
	input  wire logic                       peripheral_reset_pin1_n,
	input  wire logic                       input_clock_zero_lost,
	input  wire logic                       input_clock_one_lost,
	input  wire logic [1:0]                 input0_passthrough_setting,
	input  wire logic [1:0]                 input1_passthrough_setting,
	input  wire logic                       load_ack,
	input  wire logic                       load_ok,
	input  wire logic                       load_from_eeprom,
	input  wire logic                       load_from_otp,
	input  wire logic                       single_ended_image_flag,
	input  wire logic [sdsr_pkg::CFG_ID_W-1:0] load_config_id,
	input  wire logic                       reload_req,
	input  wire logic                       cfg_wr,
	input  wire sdsr_pkg::sdsr_wr_kind_e    cfg_wr_kind,
	input  wire logic [7:0]                 cfg_wdata,
	input  wire logic                       rd_en,
	input  wire logic                       rd_sel,
	output logic                            load_req,
	output logic                            load_user,
	output logic                            cfg_wr_ok,
	output logic                            write_lock_status,
	output logic [15:0]                     rd_data,
	output logic                            rd_valid
);
	import sdsr_pkg::*;

	sdsr_sync_if                            sif ();
	sdsr_state_e                            state_q;
	logic [PIN_FIELD_W-1:0]                 pin_val_q [PIN_COUNT];
	logic                                   cap_done_q;
	logic [2:0]                             settle_q;
	logic                                   pg_prev_q;
	logic                                   rstpin0_prev_q;
	logic                                   rstpin1_prev_q;
	logic                                   auto0_q;
	logic                                   auto1_q;
	logic                                   flag0_q;
	logic                                   flag1_q;
	logic                                   ready_q;
	logic                                   lock_q;
	logic                                   se_q;
	logic                                   ee_q;
	logic                                   otp_q;
	logic [CFG_ID_W-1:0]                    cfg_id_q;
	logic                                   common_ok_q;
	logic                                   load_req_q;
	logic                                   load_user_q;
	logic                                   wr_ok_q;
	logic [15:0]                            rd_data_q;
	logic                                   rd_valid_q;
	logic [15:0]                            pin_sts;
	logic [15:0]                            dev_sts;
	logic                                   capture_now;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [1:0] tri_code(input logic hi, input logic lo);
		if (hi)
			return TRI_HIGH;
		else if (lo)
			return TRI_LOW;
		else
			return TRI_MID;
	endfunction

	// reserved setting 2 is treated like off
	function automatic logic fan_flag(input logic [1:0] mode, input logic auto_sel);
		unique case (mode)
			FAN_AUTO:   return auto_sel;
			FAN_MANUAL: return 1'b1;
			default:    return 1'b0;
		endcase
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	assign sif.raw = {input_clock_one_lost, input_clock_zero_lost, peripheral_reset_pin1_n,
	                  peripheral_reset_pin0_n, power_good_pin, pin_level_high[2], pin_level_low[2],
	                  pin_level_high[1], pin_level_low[1], pin_level_high[0], pin_level_low[0]};

	sdsr_sync u_sync
	(
		.clk  (clk),
		.nrst (nrst),
		.sif  (sif.filt)
	);

	// ----------------------------------------
	// startup pin capture
	// ----------------------------------------
	// without a power-good pin, capture waits until the synchronisers hold real pin levels
	assign capture_now = !cap_done_q && (settle_q == SETTLE_CYCLES) &&
	                     (power_good_select ? (sif.clean[SB_PG] && !pg_prev_q) : 1'b1);

	always_ff @(posedge clk)
	if (!nrst)
	begin
		settle_q   <= 3'h0;
		pg_prev_q  <= 1'b0;
		cap_done_q <= 1'b0;
	end
	else
	begin
		if (settle_q != SETTLE_CYCLES)
			settle_q <= settle_q + 3'h1;
		pg_prev_q <= sif.clean[SB_PG];
		if (capture_now)
			cap_done_q <= 1'b1;
	end

	genvar p;
	generate
		for (p = 0; p < PIN_COUNT; p++)
		begin : g_pin
			always_ff @(posedge clk)
			if (!nrst)
				pin_val_q[p] <= TRI_LOW;
			else if (capture_now)
				pin_val_q[p] <= tri_code(sif.clean[2*p+1], sif.clean[2*p]);
		end
	endgenerate

	// ----------------------------------------
	// input clock passthrough flags
	// ----------------------------------------
	always_ff @(posedge clk)
	if (!nrst)
	begin
		rstpin0_prev_q <= 1'b1;
		rstpin1_prev_q <= 1'b1;
		auto0_q        <= 1'b0;
		auto1_q        <= 1'b0;
		flag0_q        <= 1'b0;
		flag1_q        <= 1'b0;
	end
	else
	begin
		// pins idle high; held high until settled, so leaving reset makes no false edge
		rstpin0_prev_q <= (settle_q == SETTLE_CYCLES) ? sif.clean[SB_RSTPIN0] : 1'b1;
		rstpin1_prev_q <= (settle_q == SETTLE_CYCLES) ? sif.clean[SB_RSTPIN1] : 1'b1;
		if (sif.clean[SB_RSTPIN0] && !rstpin0_prev_q)
			auto0_q <= !sif.clean[SB_LOS0];
		if (sif.clean[SB_RSTPIN1] && !rstpin1_prev_q)
			auto1_q <= !sif.clean[SB_LOS1];
		flag0_q <= fan_flag(input0_passthrough_setting, auto0_q);
		flag1_q <= fan_flag(input1_passthrough_setting, auto1_q);
	end

	// ----------------------------------------
	// configuration load sequencer
	// ----------------------------------------
	always_ff @(posedge clk)
	if (!nrst)
	begin
		state_q     <= ST_WAIT_PINS;
		load_req_q  <= 1'b0;
		load_user_q <= 1'b0;
		common_ok_q <= 1'b0;
		ready_q     <= 1'b0;
		se_q        <= 1'b0;
		ee_q        <= 1'b0;
		otp_q       <= 1'b0;
		cfg_id_q    <= '0;
	end
	else
	begin
		load_req_q <= 1'b0;
		unique case (state_q)
			ST_WAIT_PINS:
				if (cap_done_q)
				begin
					load_req_q  <= 1'b1;
					load_user_q <= 1'b0;
					state_q     <= ST_COMMON;
				end
			ST_COMMON:
				if (load_ack)
				begin
					se_q        <= single_ended_image_flag;
					common_ok_q <= 1'b1;
					load_req_q  <= 1'b1;
					load_user_q <= 1'b1;
					state_q     <= ST_USER;
				end
			ST_USER, ST_RELOAD:
				if (load_ack)
				begin
					ee_q     <= load_ok && load_from_eeprom;
					otp_q    <= load_ok && load_from_otp;
					cfg_id_q <= load_config_id;
					ready_q  <= 1'b1;
					state_q  <= ST_READY;
				end
			ST_READY:
				if (reload_req)
				begin
					ready_q     <= 1'b0;
					load_req_q  <= 1'b1;
					load_user_q <= 1'b1;
					state_q     <= ST_RELOAD;
				end
			default:
				state_q <= ST_WAIT_PINS;
		endcase
	end

	// ----------------------------------------
	// write lock
	// ----------------------------------------
	always_ff @(posedge clk)
	if (!nrst)
	begin
		lock_q  <= 1'b0;
		wr_ok_q <= 1'b0;
	end
	else
	begin
		wr_ok_q <= cfg_wr && (!lock_q || cfg_wr_kind != WR_CONFIG);
		if (cfg_wr && cfg_wr_kind == WR_LOCK_KEY)
		begin
			if (cfg_wdata == LOCK_KEY_SET)
				lock_q <= 1'b1;
			else if (cfg_wdata == LOCK_KEY_CLR)
				lock_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// read port; these registers have no write path
	// ----------------------------------------
	always_comb
	begin
		pin_sts = PIN_CAPTURE_RST;
		pin_sts[PIN_A_LSB +: PIN_FIELD_W] = pin_val_q[0];
		pin_sts[PIN_B_LSB +: PIN_FIELD_W] = pin_val_q[1];
		pin_sts[PIN_C_LSB +: PIN_FIELD_W] = pin_val_q[2];
		dev_sts = DEVICE_LOAD_STATUS_RST;
		dev_sts[FLAG_IN1_BIT] = flag1_q;
		dev_sts[FLAG_IN0_BIT] = flag0_q;
		dev_sts[READY_BIT]    = ready_q;
		dev_sts[LOCK_BIT]     = lock_q;
		dev_sts[SE_IMAGE_BIT] = se_q;
		dev_sts[EE_VALID_BIT] = ee_q;
		dev_sts[OTP_VALID_BIT] = otp_q;
		dev_sts[CFG_ID_LSB +: CFG_ID_W] = cfg_id_q;
	end

	always_ff @(posedge clk)
	if (!nrst)
	begin
		rd_data_q  <= 16'h0000;
		rd_valid_q <= 1'b0;
	end
	else
	begin
		rd_valid_q <= rd_en;
		if (rd_en)
			rd_data_q <= (rd_sel == SEL_DEVICE_STATUS) ? dev_sts : pin_sts;
	end

	assign load_req          = load_req_q;
	assign load_user         = load_user_q;
	assign cfg_wr_ok         = wr_ok_q;
	assign write_lock_status = lock_q;
	assign rd_data           = rd_data_q;
	assign rd_valid          = rd_valid_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence user_done_s;
		(state_q == ST_USER || state_q == ST_RELOAD) && load_ack;
	endsequence
	sequence reload_go_s;
		state_q == ST_READY && reload_req;
	endsequence

	pin_hold_a: assert property (cap_done_q |=> $stable(pin_sts))
		else $error("pin field changed after capture");
	pin_code_a: assert property (pin_val_q[0] != 2'h2 && pin_val_q[1] != 2'h2 && pin_val_q[2] != 2'h2)
		else $error("unused pin code produced");
	pg_capture_a: assert property (power_good_select && !cap_done_q && sif.clean[SB_PG] && !pg_prev_q
		&& settle_q == SETTLE_CYCLES |=> cap_done_q ##0 $changed(cap_done_q))
		else $error("capture missed power-good rise");
	in1_off_a: assert property (input1_passthrough_setting == FAN_OFF |=> !flag1_q)
		else $error("input-1 flag set while mode off");
	in0_manual_a: assert property (input0_passthrough_setting == FAN_MANUAL |=> flag0_q ##0 dev_sts[FLAG_IN0_BIT])
		else $error("input-0 flag clear in manual mode");
	ready_set_a: assert property (user_done_s |=> ready_q && state_q == ST_READY)
		else $error("ready not set after load");
	reload_clear_a: assert property (reload_go_s |=> !ready_q && load_req_q ##1 (!ready_q || $past(load_ack)))
		else $error("ready not cleared on reload");
	lock_drop_a: assert property (lock_q && cfg_wr && cfg_wr_kind == WR_CONFIG |=> !wr_ok_q)
		else $error("locked config write accepted");
	lock_pass_a: assert property (cfg_wr && cfg_wr_kind != WR_CONFIG |=> wr_ok_q)
		else $error("exempt write refused");
	lock_key_a: assert property (!(cfg_wr && cfg_wr_kind == WR_LOCK_KEY) |=> $stable(lock_q))
		else $error("lock changed without key write");
	common_first_a: assert property (load_req_q && load_user_q |-> common_ok_q)
		else $error("user load before common load");
	reset_zero_a: assert property (disable iff (1'b0) $rose(nrst) |-> dev_sts == 16'h0000 && pin_sts == 16'h0000)
		else $error("status not zero after reset");

endmodule

`default_nettype wire
